// ===== verilog/tx_ctrl_pkg.sv
// constants for the transmit control block
// assumes a single ref_clk domain; consumers use package::name
package tx_ctrl_pkg;
   // register offsets (word addresses on the plain port)
   localparam logic [3:0] reg_ref_addr = 4'h0;
   localparam logic [3:0] reg_mod_addr = 4'h1;
   localparam logic [3:0] reg_func_addr = 4'h2;
   localparam logic [3:0] reg_center_addr = 4'h3;
   localparam logic [3:0] reg_status_addr = 4'h4;
   // reference register fields
   localparam int clkdiv_lsb = 19;
   localparam int clkdiv_w = 4;
   localparam logic [31:0] reg_ref_reset = 32'h00400000;
   // modulation register fields
   localparam int scheme_lsb = 0;
   localparam int dev_lsb = 2;
   localparam int dev_w = 9;
   localparam int gexp_lsb = 11;
   localparam int gexp_w = 3;
   localparam int gdiv_lsb = 14;
   localparam int gdiv_w = 7;
   localparam int step_lsb = 21;
   localparam logic [31:0] reg_mod_reset = 32'h00000000;
   // function register fields
   localparam int clkbuf_bit = 4;
   localparam int amp_on_bit = 5;
   localparam int bias_lsb = 6;
   localparam int mux_lsb = 10;
   localparam int amp_lvl_lsb = 14;
   localparam int amp_lvl_w = 6;
   localparam logic [31:0] reg_func_reset = 32'h000000d0;
   localparam logic [31:0] reg_center_reset = 32'h00000000;
   // status mux codes
   localparam logic [3:0] mux_reg_ready = 4'h0;
   localparam logic [3:0] mux_tx_bit = 4'h1;
   localparam logic [3:0] mux_clk_out = 4'h2;
   // scheme codes
   localparam logic [1:0] scheme_fsk = 2'h0;
   // regulator power-on time
   localparam int reg_on_time_us = 100;
   localparam int clk_mhz = 200;
   localparam int reg_on_cycles = reg_on_time_us * clk_mhz;
   // step count per symbol for each index counter code
   localparam logic [7:0] step_tab0 = 8'h10;
   localparam logic [7:0] step_tab1 = 8'h20;
   localparam logic [7:0] step_tab2 = 8'h40;
   localparam logic [7:0] step_tab3 = 8'h80;
   localparam int max_steps = 128;
   localparam int clkdiv_min = 2;
   localparam int clkdiv_max = 30;
endpackage

// ===== verilog/fsk_gfsk_transmit_control.sv
// transmit control: clock output divider, chip enable gating, fsk/gfsk n stepping
// assumes pins synchronous to ref_clk; pfd tick is a one-cycle strobe from the pll
//
// Decided for this implementation: the address map and the strobed register port.
`timescale 1ns/1ps

// Functional notes
// - even clock out divide 2..30, 50:50
// - clock divider resets to divide by 16
// - clock out buffer bit, high at reset
// - chip enable low returns all registers to their reset values
// - status output defaults to regulator ready
// - fsk samples data every pfd tick
// - rising data adds deviation to centre
// - falling data subtracts deviation from centre
// - nine-bit fsk deviation field
// - scheme select zero means plain fsk
// - gfsk steps per symbol from index counter
// - gaussian sample clock driven on pin
// - sample data on sample clock rising edge
// - gfsk deviation is two to the m
// - sample clock rate pfd over factor*index
// - six-bit amplifier level field
// - amplifier off when power bit low
// - four-bit select chooses status output
module fsk_gfsk_transmit_control #(
   parameter int reg_on_cycles = tx_ctrl_pkg::reg_on_cycles,
   parameter int n_w = 24,
   parameter logic [1:0] gauss_fsk_code = 2'h1
) (
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic clk_en,
   input wire logic chip_en,
   input wire logic pfd_tick,
   input wire logic [3:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [31:0] rdata,
   input wire logic tx_bit_in,
   output logic tx_sample_clock_out,
   output logic clock_out,
   output logic status_mux_out,
   output logic [n_w-1:0] synth_n,
   output logic [5:0] amp_level,
   output logic amp_enable,
   output logic [3:0] osc_bias_field
);
   initial begin
      if (n_w < 16 || n_w > 32 || reg_on_cycles < 1) begin
         $error("unsupported parameter");
      end
   end

   localparam int cnt_w = $clog2(reg_on_cycles + 1);

   logic [31:0] reg_ref, next_reg_ref;
   logic [31:0] reg_mod, next_reg_mod;
   logic [31:0] reg_func, next_reg_func;
   logic [31:0] reg_center, next_reg_center;
   logic [31:0] next_rdata;
   logic [cnt_w-1:0] on_cnt, next_on_cnt;
   logic reg_ready, next_reg_ready;
   logic [3:0] div_cnt, next_div_cnt;
   logic clk_ph, next_clk_ph;
   logic last_bit, next_last_bit;
   logic [n_w-1:0] offset, next_offset;
   logic [n_w-1:0] target, next_target;
   logic [n_w-1:0] next_synth_n;
   logic [6:0] gdiv_cnt, next_gdiv_cnt;
   logic [7:0] step_cnt, next_step_cnt;
   logic samp_clk, next_samp_clk;
   logic next_status;

   logic [3:0] div_sel;
   logic [1:0] scheme;
   logic [8:0] fsk_dev;
   logic [2:0] gauss_deviation_exp;
   logic [6:0] gauss_divider_factor;
   logic [1:0] step_sel;
   logic [7:0] steps;
   logic [3:0] status_mux_select;
   logic [n_w-1:0] fsk_dev_n, gauss_dev_n, gauss_step_n;
   logic gauss_mode;

   assign div_sel = reg_ref[tx_ctrl_pkg::clkdiv_lsb +: tx_ctrl_pkg::clkdiv_w];
   assign scheme = reg_mod[tx_ctrl_pkg::scheme_lsb +: 2];
   assign fsk_dev = reg_mod[tx_ctrl_pkg::dev_lsb +: tx_ctrl_pkg::dev_w];
   assign gauss_deviation_exp = reg_mod[tx_ctrl_pkg::gexp_lsb +: tx_ctrl_pkg::gexp_w];
   assign gauss_divider_factor = reg_mod[tx_ctrl_pkg::gdiv_lsb +: tx_ctrl_pkg::gdiv_w];
   assign step_sel = reg_mod[tx_ctrl_pkg::step_lsb +: 2];
   assign status_mux_select = reg_func[tx_ctrl_pkg::mux_lsb +: 4];
   assign gauss_mode = (scheme == gauss_fsk_code);
   // fsk unit is f_pfd/2^14, gauss unit 2^m/2^12 = 2^(m+2) fsk units
   assign fsk_dev_n = n_w'(fsk_dev);
   assign gauss_dev_n = n_w'(32'h4 << gauss_deviation_exp);

   always_comb begin
      case (step_sel)
         2'h0: steps = tx_ctrl_pkg::step_tab0;
         2'h1: steps = tx_ctrl_pkg::step_tab1;
         2'h2: steps = tx_ctrl_pkg::step_tab2;
         default: steps = tx_ctrl_pkg::step_tab3;
      endcase
   end
   // the shifted step is forced odd, so never zero; a clamp keeps the final value reachable
   assign gauss_step_n = (gauss_dev_n >> $clog2(32'(steps))) | n_w'(1);

   // register file and chip enable
   always_comb begin
      next_reg_ref = reg_ref;
      next_reg_mod = reg_mod;
      next_reg_func = reg_func;
      next_reg_center = reg_center;
      next_rdata = 32'h0;
      next_on_cnt = on_cnt;
      next_reg_ready = reg_ready;
      if (!chip_en) begin
         next_reg_ref = tx_ctrl_pkg::reg_ref_reset;
         next_reg_mod = tx_ctrl_pkg::reg_mod_reset;
         next_reg_func = tx_ctrl_pkg::reg_func_reset;
         next_reg_center = tx_ctrl_pkg::reg_center_reset;
         next_on_cnt = '0;
         next_reg_ready = 1'b0;
      end else begin
         if (!reg_ready) begin
            if (on_cnt == cnt_w'(reg_on_cycles - 1)) begin
               next_reg_ready = 1'b1;
            end
            next_on_cnt = on_cnt + cnt_w'(1);
         end
         // writes before regulator ready are lost, as the serial port is unpowered
         if (wr && reg_ready) begin
            case (addr)
               tx_ctrl_pkg::reg_ref_addr: next_reg_ref = wdata;
               tx_ctrl_pkg::reg_mod_addr: next_reg_mod = wdata;
               tx_ctrl_pkg::reg_func_addr: next_reg_func = wdata;
               tx_ctrl_pkg::reg_center_addr: next_reg_center = wdata;
               default: ;
            endcase
         end
         if (rd) begin
            case (addr)
               tx_ctrl_pkg::reg_ref_addr: next_rdata = reg_ref;
               tx_ctrl_pkg::reg_mod_addr: next_rdata = reg_mod;
               tx_ctrl_pkg::reg_func_addr: next_rdata = reg_func;
               tx_ctrl_pkg::reg_center_addr: next_rdata = reg_center;
               tx_ctrl_pkg::reg_status_addr: next_rdata = {29'h0, samp_clk, last_bit, reg_ready};
               default: next_rdata = 32'h0;
            endcase
         end
      end
   end

   // clock output divider
   always_comb begin
      next_div_cnt = div_cnt;
      next_clk_ph = clk_ph;
      if (!chip_en) begin
         next_div_cnt = '0;
         next_clk_ph = 1'b0;
      end else if (div_cnt + 4'h1 >= div_sel || div_sel == 4'h0) begin
         // half period of div_sel cycles gives an even ratio 2*div_sel
         next_div_cnt = '0;
         next_clk_ph = ~clk_ph;
      end else begin
         next_div_cnt = div_cnt + 4'h1;
      end
   end

   // modulation datapath
   always_comb begin
      next_last_bit = last_bit;
      next_offset = offset;
      next_target = target;
      next_gdiv_cnt = gdiv_cnt;
      next_step_cnt = step_cnt;
      next_samp_clk = samp_clk;
      next_synth_n = synth_n;
      if (!chip_en) begin
         next_last_bit = 1'b0;
         next_offset = '0;
         next_target = '0;
         next_gdiv_cnt = '0;
         next_step_cnt = '0;
         next_samp_clk = 1'b0;
         next_synth_n = '0;
      end else if (pfd_tick) begin
         if (scheme == tx_ctrl_pkg::scheme_fsk) begin
            next_last_bit = tx_bit_in;
            if (tx_bit_in) begin
               next_offset = fsk_dev_n;
            end else begin
               next_offset = '0 - fsk_dev_n;
            end
            next_samp_clk = 1'b0;
         end else if (gauss_mode) begin
            // one gaussian step per factor ticks; steps per symbol from index counter
            if (gdiv_cnt + 7'h1 >= gauss_divider_factor) begin
               next_gdiv_cnt = '0;
               if (step_cnt + 8'h1 >= steps) begin
                  next_step_cnt = '0;
               end else begin
                  next_step_cnt = step_cnt + 8'h1;
               end
               if (step_cnt == 8'h0) begin
                  next_samp_clk = 1'b0;
               end else if (step_cnt == (steps >> 1)) begin
                  next_samp_clk = 1'b1;
                  next_last_bit = tx_bit_in;
                  next_target = tx_bit_in ? gauss_dev_n : '0 - gauss_dev_n;
               end
               if ($signed(offset) < $signed(target)) begin
                  if ($signed(target - offset) <= $signed(gauss_step_n)) begin
                     next_offset = target;
                  end else begin
                     next_offset = offset + gauss_step_n;
                  end
               end else if ($signed(offset) > $signed(target)) begin
                  if ($signed(offset - target) <= $signed(gauss_step_n)) begin
                     next_offset = target;
                  end else begin
                     next_offset = offset - gauss_step_n;
                  end
               end
            end else begin
               next_gdiv_cnt = gdiv_cnt + 7'h1;
            end
         end else begin
            // keying modes leave the carrier at centre
            next_offset = '0;
            next_samp_clk = 1'b0;
         end
         next_synth_n = reg_center[n_w-1:0] + next_offset;
      end
   end

   always_comb begin
      case (status_mux_select)
         tx_ctrl_pkg::mux_reg_ready: next_status = reg_ready;
         tx_ctrl_pkg::mux_tx_bit: next_status = last_bit;
         tx_ctrl_pkg::mux_clk_out: next_status = clk_ph;
         default: next_status = 1'b0;
      endcase
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         reg_ref <= tx_ctrl_pkg::reg_ref_reset;
         reg_mod <= tx_ctrl_pkg::reg_mod_reset;
         reg_func <= tx_ctrl_pkg::reg_func_reset;
         reg_center <= tx_ctrl_pkg::reg_center_reset;
         rdata <= 32'h0;
         on_cnt <= '0;
         reg_ready <= 1'b0;
         div_cnt <= '0;
         clk_ph <= 1'b0;
         last_bit <= 1'b0;
         offset <= '0;
         target <= '0;
         gdiv_cnt <= '0;
         step_cnt <= '0;
         samp_clk <= 1'b0;
         synth_n <= '0;
         status_mux_out <= 1'b0;
      end else if (clk_en) begin
         reg_ref <= next_reg_ref;
         reg_mod <= next_reg_mod;
         reg_func <= next_reg_func;
         reg_center <= next_reg_center;
         rdata <= next_rdata;
         on_cnt <= next_on_cnt;
         reg_ready <= next_reg_ready;
         div_cnt <= next_div_cnt;
         clk_ph <= next_clk_ph;
         last_bit <= next_last_bit;
         offset <= next_offset;
         target <= next_target;
         gdiv_cnt <= next_gdiv_cnt;
         step_cnt <= next_step_cnt;
         samp_clk <= next_samp_clk;
         synth_n <= next_synth_n;
         status_mux_out <= next_status;
      end
   end

   assign clock_out = clk_ph & reg_func[tx_ctrl_pkg::clkbuf_bit];
   assign tx_sample_clock_out = samp_clk & gauss_mode;
   assign amp_level = reg_func[tx_ctrl_pkg::amp_lvl_lsb +: tx_ctrl_pkg::amp_lvl_w];
   assign amp_enable = reg_func[tx_ctrl_pkg::amp_on_bit] & chip_en;
   // software keeps this field away from codes 0, e and f
   assign osc_bias_field = reg_func[tx_ctrl_pkg::bias_lsb +: 4];
endmodule

// ===== tb/host_model.sv
// host side model: pfd tick source and transmit data source
// assumes ref_clk domain; the bench picks the mode and the bit pattern
`timescale 1ns/1ps
module host_model (
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic tx_sample_clock_out,
   input wire logic gauss,
   input wire logic fsk_bit,
   input wire logic [7:0] pattern,
   output logic pfd_tick,
   output logic tx_bit_in
);
   logic prev_samp;
   logic [2:0] idx;
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         pfd_tick <= 1'b0;
         prev_samp <= 1'b0;
         idx <= 3'h0;
         tx_bit_in <= 1'b0;
      end else begin
         pfd_tick <= !pfd_tick;
         prev_samp <= tx_sample_clock_out;
         if (!gauss) begin
            tx_bit_in <= fsk_bit;
         end else if (prev_samp && !tx_sample_clock_out) begin
            // new bit only after a falling sample edge, so it is steady at the rising one
            tx_bit_in <= pattern[idx];
            idx <= idx + 3'h1;
         end
      end
   end
endmodule

// ===== tb/tx_ctrl_monitor.sv
// port checks for the transmit control block
// assumes clk_en held high by the bench
`timescale 1ns/1ps
module tx_ctrl_monitor #(
   parameter int reg_on_cycles = 10
) (
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic chip_en,
   input wire logic pfd_tick,
   input wire logic [3:0] addr,
   input wire logic wr,
   input wire logic rd,
   input wire logic [31:0] rdata,
   input wire logic tx_sample_clock_out,
   input wire logic status_mux_out,
   input wire logic [23:0] synth_n,
   input wire logic [5:0] amp_level,
   input wire logic amp_enable,
   input wire logic [3:0] osc_bias_field
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rstn);
   int on_cnt;
   int next_on_cnt;
   always_comb begin
      next_on_cnt = on_cnt;
      if (!chip_en) next_on_cnt = 0;
      else if (on_cnt < 100000) next_on_cnt = on_cnt + 1;
   end
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) on_cnt <= 0;
      else on_cnt <= next_on_cnt;
   end
   sequence ce_off3;
      !chip_en [*3];
   endsequence
   sequence no_tick;
      !pfd_tick && chip_en ##1 chip_en;
   endsequence
   sequence no_write;
      !wr && chip_en ##1 chip_en;
   endsequence
   amp_gate_a: assert property (!chip_en |=> !amp_enable)
      else $error("amplifier on without chip enable");
   ce_clear_a: assert property (!chip_en |=> amp_level == 6'h0 && osc_bias_field == 4'h3)
      else $error("registers kept while chip enable low");
   ready_wait_a: assert property (on_cnt > 1 && on_cnt < reg_on_cycles |-> !status_mux_out)
      else $error("ready shown too early");
   ready_off_a: assert property (ce_off3 |-> !status_mux_out)
      else $error("ready shown while powered down");
   samp_idle_a: assert property (!chip_en |=> !tx_sample_clock_out)
      else $error("sample clock active in reset mode");
   synth_hold_a: assert property (no_tick |-> $stable(synth_n))
      else $error("n value moved without a pfd tick");
   level_hold_a: assert property (no_write |-> $stable(amp_level) && $stable(osc_bias_field))
      else $error("function fields moved without a write");
   status_rd_a: assert property (rd && addr == 4'h4 |=> rdata[31:3] == 29'h0)
      else $error("status read has stray bits");
endmodule
bind fsk_gfsk_transmit_control tx_ctrl_monitor #(.reg_on_cycles(reg_on_cycles)) mon (
   .ref_clk(ref_clk), .rstn(rstn), .chip_en(chip_en), .pfd_tick(pfd_tick), .addr(addr),
   .wr(wr), .rd(rd), .rdata(rdata), .tx_sample_clock_out(tx_sample_clock_out),
   .status_mux_out(status_mux_out), .synth_n(synth_n), .amp_level(amp_level),
   .amp_enable(amp_enable), .osc_bias_field(osc_bias_field));

// ===== tb/tb.sv
// self-checking bench for the transmit control block
// assumes host_model and the bound monitor are compiled first
`timescale 1ns/1ps
module tb;
   logic ref_clk, rstn, chip_en, wr, rd, gauss, fsk_bit, pfd_tick, tx_bit_in;
   logic tx_sample_clock_out, clock_out, status_mux_out, amp_enable;
   logic [3:0] addr, osc_bias_field;
   logic [31:0] wdata, rdata;
   logic [7:0] pattern;
   logic [23:0] synth_n;
   logic [5:0] amp_level;
   int error_cnt, checked, cyc, n;
   fsk_gfsk_transmit_control #(.reg_on_cycles(10)) DUT (.ref_clk(ref_clk), .rstn(rstn),
      .clk_en(1'b1), .chip_en(chip_en), .pfd_tick(pfd_tick), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata(rdata), .tx_bit_in(tx_bit_in),
      .tx_sample_clock_out(tx_sample_clock_out), .clock_out(clock_out),
      .status_mux_out(status_mux_out), .synth_n(synth_n), .amp_level(amp_level),
      .amp_enable(amp_enable), .osc_bias_field(osc_bias_field));
   host_model host (.ref_clk(ref_clk), .rstn(rstn), .tx_sample_clock_out(tx_sample_clock_out),
      .gauss(gauss), .fsk_bit(fsk_bit), .pattern(pattern), .pfd_tick(pfd_tick),
      .tx_bit_in(tx_bit_in));
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[ERR] %0t got %h want %h", $time, seen, exp);
      end
   endtask
   task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge ref_clk);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [3:0] a, input logic [31:0] exp);
      @(posedge ref_clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge ref_clk);
      rd <= 1'b0;
      #1 chk(rdata, exp);
   endtask
   // skips the partial half in progress, then counts one whole half period
   task automatic half_len(ref logic s, output int len);
      logic v;
      // falling edges keep the sample clear of the launching rising edge
      @(negedge ref_clk);
      v = s;
      while (s === v) @(negedge ref_clk);
      v = s;
      len = 0;
      while (s === v) begin
         @(negedge ref_clk);
         len++;
      end
   endtask
   task automatic wait_ready();
      n = 0;
      while (status_mux_out !== 1'b1 && n < 40) begin
         @(posedge ref_clk);
         n++;
      end
      chk(status_mux_out, 1'b1);
   endtask
   task automatic t_power();
      wr_reg(4'h2, 32'h00000020);
      rd_reg(4'h2, 32'h000000d0);
      rd_reg(4'h0, 32'h00400000);
      rd_reg(4'h1, 32'h0);
      rd_reg(4'h9, 32'h0);
      wait_ready();
      rd_reg(4'h4, 32'h1);
      half_len(clock_out, n);
      half_len(clock_out, n);
      chk(n, 8);
   endtask
   task automatic t_clk();
      int v[3] = '{1, 2, 15};
      foreach (v[i]) begin
         wr_reg(4'h0, 32'(v[i]) << 19);
         half_len(clock_out, n);
         half_len(clock_out, n);
         chk(n, v[i]);
      end
      wr_reg(4'h2, 32'h000000c0);
      repeat (2) @(posedge ref_clk);
      repeat (20) begin
         @(posedge ref_clk);
         chk(clock_out, 1'b0);
      end
   endtask
   task automatic t_gauss();
      wr_reg(4'h3, 32'h00001000);
      gauss <= 1'b1;
      pattern <= 8'hff;
      for (int i = 0; i < 4; i++) begin
         wr_reg(4'h1, 32'h00009001 | (32'(i) << 21));
         half_len(tx_sample_clock_out, n);
         half_len(tx_sample_clock_out, n);
         chk(n, 32 << i);
      end
      wr_reg(4'h1, 32'h00009001);
      repeat (300) @(posedge ref_clk);
      chk(synth_n, 24'h001010);
      pattern <= 8'h00;
      repeat (300) @(posedge ref_clk);
      chk(synth_n, 24'h000ff0);
      gauss <= 1'b0;
   endtask
   task automatic t_fsk();
      wr_reg(4'h1, 32'h000007fc);
      wr_reg(4'h2, 32'h000fc530);
      fsk_bit <= 1'b1;
      repeat (6) @(posedge ref_clk);
      chk(synth_n, 24'h0011ff);
      chk(status_mux_out, 1'b1);
      chk(amp_enable, 1'b1);
      chk({amp_level, osc_bias_field}, {6'h3f, 4'h4});
      fsk_bit <= 1'b0;
      repeat (6) @(posedge ref_clk);
      chk(synth_n, 24'h000e01);
      wr_reg(4'h1, 32'h000007fe);
      repeat (6) @(negedge ref_clk);
      chk(synth_n, 24'h001000);
      chk(tx_sample_clock_out, 1'b0);
      chip_en <= 1'b0;
      repeat (3) @(posedge ref_clk);
      chk(amp_enable, 1'b0);
      chip_en <= 1'b1;
      rd_reg(4'h2, 32'h000000d0);
      rd_reg(4'h3, 32'h0);
      wait_ready();
   endtask
   task automatic conclude();
      if (error_cnt == 0 && checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   initial begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = !ref_clk;
   end
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 10000) begin
         error_cnt++;
         conclude();
      end
   end
   initial begin
      rstn = 1'b0;
      chip_en = 1'b1;
      wr = 1'b0;
      rd = 1'b0;
      addr = 4'h0;
      wdata = 32'h0;
      gauss = 1'b0;
      fsk_bit = 1'b0;
      pattern = 8'h00;
      repeat (3) @(posedge ref_clk);
      rstn <= 1'b1;
      t_power();
      t_clk();
      t_gauss();
      t_fsk();
      conclude();
   end
endmodule
